// ---- design/led_mix_pkg.sv ----
/*
 * Constants for the LED output stage: register offsets, field positions,
 * reset values, PWM timing and channel state codes.
 * Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package led_mix_pkg;

   localparam int CLK_HZ = 50_000_000;
   localparam int IND_PWM_HZ = 97_000;
   localparam int DIM_PWM_HZ = 190;
   localparam int BLINK_MAX_HZ = 24;
   localparam int PWM_STEPS = 256;
   // Longest step that still keeps each PWM at or above its nominal rate
   localparam int IND_STEP_CYCLES = CLK_HZ / (IND_PWM_HZ * PWM_STEPS);
   localparam int DIM_STEP_CYCLES = CLK_HZ / (DIM_PWM_HZ * PWM_STEPS);
   localparam int BLINK_STEP_CYCLES = CLK_HZ / (BLINK_MAX_HZ * PWM_STEPS);
   localparam int MAX_CHANNELS = 4;
   localparam int PRE_W = 14;

   localparam logic [5:0] ADDR_MODE = 6'h00;
   localparam logic [5:0] ADDR_STATE_SEL = 6'h04;
   localparam logic [5:0] ADDR_GROUP_DUTY = 6'h08;
   localparam logic [5:0] ADDR_GROUP_FREQ = 6'h0C;
   localparam logic [5:0] ADDR_DUTY0 = 6'h10;
   localparam logic [5:0] ADDR_DUTY1 = 6'h14;
   localparam logic [5:0] ADDR_DUTY2 = 6'h18;
   localparam logic [5:0] ADDR_DUTY3 = 6'h1C;
   localparam logic [5:0] ADDR_STATUS = 6'h20;

   // Fields of mode_control_two
   localparam int DIS_LSB = 0;
   localparam int DRIVE_BIT = 2;
   localparam int INVERT_BIT = 4;
   localparam int BLINK_BIT = 5;

   // Totem-pole, not inverted, disabled pins driven high: LEDs off at power-up
   localparam logic [7:0] MODE_RESET = 8'h05;
   localparam logic [7:0] STATE_SEL_RESET = 8'h00;
   localparam logic [7:0] DUTY_RESET = 8'h00;
   localparam logic [7:0] GROUP_DUTY_RESET = 8'hFF;
   localparam logic [7:0] GROUP_FREQ_RESET = 8'h00;

   localparam logic [1:0] ST_OFF = 2'h0;
   localparam logic [1:0] ST_ON = 2'h1;
   localparam logic [1:0] ST_IND = 2'h2;
   localparam logic [1:0] ST_GROUP = 2'h3;

   localparam logic [1:0] DIS_LOW = 2'h0;
   localparam logic [1:0] DIS_HIGH = 2'h1;
   localparam logic [1:0] DIS_HIZ = 2'h2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- design/led_output_stage_pwm_mix.sv ----
/*
 * Four-channel LED output stage: individual and group PWM generators,
 * per-channel state selection, inversion, drive type and the active-low
 * output-enable override, with an AXI4-Lite register slave.
 * Assumes one 50 MHz clock with synchronous active-high reset; the output
 * enable pin is asynchronous and gates the transistor enables directly.
 */
`timescale 1ns/1ps
module led_output_stage_pwm_mix
   import led_mix_pkg::*;
#(
   parameter int CHANNELS = MAX_CHANNELS,
   parameter int DIM_STEP = DIM_STEP_CYCLES,
   parameter int BLINK_STEP = BLINK_STEP_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic output_enable_n,
   output logic [CHANNELS-1:0] led_high_drive,
   output logic [CHANNELS-1:0] led_low_drive,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   generate
      if (CHANNELS < 1 || CHANNELS > MAX_CHANNELS) begin : g_bad_ch
         $error("CHANNELS must be 1 to 4");
      end
      // A one-clock dimming step would tick every cycle and break the step-length check
      if (DIM_STEP < 2 || BLINK_STEP < 1 || DIM_STEP >= (1 << PRE_W) || BLINK_STEP >= (1 << PRE_W)) begin : g_bad_step
         $error("group step counts out of range");
      end
   endgenerate

   function automatic logic [1:0] state_of(input logic [7:0] sel, input int ch);
      state_of = sel[2*ch +: 2];
   endfunction

   function automatic logic addr_is(input logic [5:0] a, input logic [5:0] off);
      addr_is = (a == off);
   endfunction

   // Registers
   logic [7:0] mode_control_two;
   logic [7:0] channel_state_select;
   logic [7:0] group_duty;
   logic [7:0] group_freq;
   logic [7:0] channel_duty [MAX_CHANNELS];

   wire [1:0] disabled_output_state = mode_control_two[DIS_LSB +: 2];
   wire output_drive_type = mode_control_two[DRIVE_BIT];
   wire output_invert = mode_control_two[INVERT_BIT];
   wire dim_blink_select = mode_control_two[BLINK_BIT];

   // Individual PWM time base, common to every channel
   localparam logic [PRE_W-1:0] IND_LAST = PRE_W'(IND_STEP_CYCLES - 1);
   logic [PRE_W-1:0] ind_pre;
   logic [7:0] ind_cnt;
   wire ind_tick = (ind_pre == IND_LAST);

   always_ff @(posedge clk) begin
      if (rst) begin
         ind_pre <= '0;
         ind_cnt <= 8'h00;
      end else begin
         ind_pre <= ind_tick ? '0 : ind_pre + 1'b1;
         if (ind_tick) begin
            ind_cnt <= ind_cnt + 8'h01;
         end
      end
   end

   // Group PWM: one generator, dimming or blinking, shared by all channels
   localparam logic [PRE_W-1:0] DIM_LAST = PRE_W'(DIM_STEP - 1);
   localparam logic [PRE_W-1:0] BLINK_LAST = PRE_W'(BLINK_STEP - 1);
   logic [PRE_W-1:0] grp_pre;
   logic [7:0] grp_div;
   logic [7:0] grp_cnt;
   wire [PRE_W-1:0] grp_last = dim_blink_select ? BLINK_LAST : DIM_LAST;
   wire grp_pre_end = (grp_pre == grp_last);
   // Blinking stretches each step by group_freq+1 base steps
   // At or above, so lowering the period mid-step cannot stall for a full divider wrap
   wire grp_div_end = !dim_blink_select || (grp_div >= group_freq);
   wire grp_tick = grp_pre_end && grp_div_end;

   always_ff @(posedge clk) begin
      if (rst) begin
         grp_pre <= '0;
         grp_div <= 8'h00;
         grp_cnt <= 8'h00;
      end else begin
         // A mode switch can leave the prescaler above the new limit; wrap it
         grp_pre <= (grp_pre_end || grp_pre > grp_last) ? '0 : grp_pre + 1'b1;
         if (grp_pre_end) begin
            grp_div <= grp_div_end ? 8'h00 : grp_div + 8'h01;
         end
         if (grp_tick) begin
            grp_cnt <= grp_cnt + 8'h01;
         end
      end
   end

   wire grp_pwm = (grp_cnt < group_duty);

   // Output mixing. pull_low: lower transistor on; upper on only in totem-pole.
   logic [CHANNELS-1:0] ind_pwm;
   logic [CHANNELS-1:0] active;
   logic [CHANNELS-1:0] pull_low;
   logic [CHANNELS-1:0] run_high;
   logic [CHANNELS-1:0] run_low;
   wire dis_low = (disabled_output_state == DIS_LOW);
   wire dis_high = (disabled_output_state == DIS_HIGH) && output_drive_type;

   genvar gi;
   generate
      for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
         wire [1:0] st = state_of(channel_state_select, gi);
         assign ind_pwm[gi] = (ind_cnt < channel_duty[gi]);
         assign active[gi] = (st == ST_ON) ||
                             (st == ST_IND && ind_pwm[gi]) ||
                             (st == ST_GROUP && ind_pwm[gi] && grp_pwm);
         assign pull_low[gi] = active[gi] ^ output_invert;
         assign run_low[gi] = pull_low[gi];
         assign run_high[gi] = !pull_low[gi] && output_drive_type;
         // Raw pin used on purpose: the override must not wait for a clock
         assign led_low_drive[gi] = output_enable_n ? dis_low : run_low[gi];
         assign led_high_drive[gi] = output_enable_n ? dis_high : run_high[gi];
      end
   endgenerate

   // Output enable synchronised for the status register only
   logic oe_meta;
   logic oe_sync;
   always_ff @(posedge clk) begin
      if (rst) begin
         oe_meta <= 1'b0;
         oe_sync <= 1'b0;
      end else begin
         oe_meta <= output_enable_n;
         oe_sync <= oe_meta;
      end
   end

   // AXI4-Lite write: address and data accepted in either order
   logic aw_held;
   logic w_held;
   logic [5:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane0;
   wire do_write = aw_held && w_held && !s_axi_bvalid;
   wire wr_lane = do_write && w_lane0;
   wire wr_duty = (aw_addr >= ADDR_DUTY0) && (aw_addr <= ADDR_DUTY3) && (aw_addr[1:0] == 2'h0);
   wire [1:0] wr_ch = aw_addr[3:2];
   wire wr_known = addr_is(aw_addr, ADDR_MODE) || addr_is(aw_addr, ADDR_STATE_SEL) ||
                   addr_is(aw_addr, ADDR_GROUP_DUTY) || addr_is(aw_addr, ADDR_GROUP_FREQ) ||
                   wr_duty || addr_is(aw_addr, ADDR_STATUS);

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 6'h00;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_control_two <= MODE_RESET;
         channel_state_select <= STATE_SEL_RESET;
         group_duty <= GROUP_DUTY_RESET;
         group_freq <= GROUP_FREQ_RESET;
         for (int i = 0; i < MAX_CHANNELS; i++) begin
            channel_duty[i] <= DUTY_RESET;
         end
      end else if (wr_lane) begin
         if (addr_is(aw_addr, ADDR_MODE)) mode_control_two <= w_byte;
         if (addr_is(aw_addr, ADDR_STATE_SEL)) channel_state_select <= w_byte;
         if (addr_is(aw_addr, ADDR_GROUP_DUTY)) group_duty <= w_byte;
         if (addr_is(aw_addr, ADDR_GROUP_FREQ)) group_freq <= w_byte;
         if (wr_duty) channel_duty[wr_ch] <= w_byte;
      end
   end

   // AXI4-Lite read
   wire rd_duty = (s_axi_araddr >= ADDR_DUTY0) && (s_axi_araddr <= ADDR_DUTY3) && (s_axi_araddr[1:0] == 2'h0);
   wire [7:0] status_bits = {5'h00, dim_blink_select, grp_pwm, oe_sync};
   wire rd_known = addr_is(s_axi_araddr, ADDR_MODE) || addr_is(s_axi_araddr, ADDR_STATE_SEL) ||
                   addr_is(s_axi_araddr, ADDR_GROUP_DUTY) || addr_is(s_axi_araddr, ADDR_GROUP_FREQ) ||
                   rd_duty || addr_is(s_axi_araddr, ADDR_STATUS);
   wire [7:0] rd_byte =
      addr_is(s_axi_araddr, ADDR_MODE) ? mode_control_two :
      addr_is(s_axi_araddr, ADDR_STATE_SEL) ? channel_state_select :
      addr_is(s_axi_araddr, ADDR_GROUP_DUTY) ? group_duty :
      addr_is(s_axi_araddr, ADDR_GROUP_FREQ) ? group_freq :
      rd_duty ? channel_duty[s_axi_araddr[3:2]] :
      addr_is(s_axi_araddr, ADDR_STATUS) ? status_bits : 8'h00;

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_byte};
         s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   wire [1:0] st0 = state_of(channel_state_select, 0);

   a_oe_force_low: assert property (output_enable_n && dis_low |-> led_low_drive[0] && !led_high_drive[0])
      else $error("disabled state 00 did not pull low");
   a_oe_force_hiz: assert property (output_enable_n && disabled_output_state == DIS_HIZ
      |-> led_low_drive == '0 && led_high_drive == '0)
      else $error("disabled state 10 did not float");
   a_on_pulls_low: assert property (!output_enable_n && !output_invert && st0 == ST_ON |-> led_low_drive[0])
      else $error("on state did not pull low");
   a_invert_off_low: assert property (!output_enable_n && output_invert && st0 == ST_OFF
      |-> led_low_drive[0] && !led_high_drive[0])
      else $error("inverted off state did not pull low");
   a_od_upper_off: assert property (!output_enable_n && !output_drive_type |-> led_high_drive == '0)
      else $error("open-drain turned upper on");
   a_no_shoot_thru: assert property ((led_high_drive & led_low_drive) == '0)
      else $error("both transistors on");
   a_ind_step_adv: assert property (ind_tick |=> ind_cnt == $past(ind_cnt) + 8'h01)
      else $error("individual PWM counter did not advance");
   a_group_gates_ch: assert property (!output_enable_n && !output_invert && st0 == ST_GROUP && !grp_pwm
      |-> !led_low_drive[0])
      else $error("group PWM low did not gate channel");
   a_dim_step_len: assert property (!dim_blink_select && grp_tick ##1 !dim_blink_select |-> !grp_tick)
      else $error("group dimming ticked twice in a row");

   c_group_wrap: cover property (grp_tick && grp_cnt == 8'hFF);
   c_oe_override: cover property (output_enable_n && disabled_output_state == DIS_HIGH);
   c_mix_low: cover property (!output_enable_n && st0 == ST_GROUP && led_low_drive[0]);
   c_blink_step: cover property (dim_blink_select && grp_tick);

endmodule

// ---- tb/led_pin_load.sv ----
/*
 Pin load beside the LED output stage: an LED and resistor from each
 pin to the supply, so an undriven pin rests high.
 Assumes one upper and one lower transistor enable per channel.
*/
`timescale 1ns/1ps
module led_pin_load #(
   parameter int CHANNELS = 4
) (
   input wire logic [CHANNELS-1:0] high_drive,
   input wire logic [CHANNELS-1:0] low_drive,
   output logic [CHANNELS-1:0] pin_level,
   output logic contention
);
   // Released pins rise through the LED resistor, never float
   assign pin_level = ~low_drive;
   // Both transistors on would short the supply
   assign contention = |(high_drive & low_drive);
endmodule

// ---- tb/led_output_stage_pwm_mix_bench.sv ----
/*
 Self-checking bench for the LED output stage: AXI4-Lite tasks,
 static state, override and PWM duty measurements.
 Assumes shortened group steps of 4 and 3 clocks.
*/
`timescale 1ns/1ps
module led_output_stage_pwm_mix_bench
   import led_mix_pkg::*;
;
   logic clk, rst, oe_n, awv, wv, bv, br, arv, rv, rr, awr, wr_rdy, arr, cont;
   logic [5:0] awa, ara;
   logic [31:0] wd, rd;
   logic [3:0] ws, hi, lo, pin;
   logic [1:0] bresp, rresp;
   logic [3:0][7:0] duty;
   int mismatches, cmp_count, cycles;
   led_output_stage_pwm_mix #(.CHANNELS(4), .DIM_STEP(4), .BLINK_STEP(3)) i_led_output_stage_pwm_mix (
      .clk(clk), .rst(rst), .output_enable_n(oe_n), .led_high_drive(hi), .led_low_drive(lo),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
   led_pin_load #(.CHANNELS(4)) i_led_pin_load (.high_drive(hi), .low_drive(lo), .pin_level(pin),
      .contention(cont));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
      check_word({30'h0, got}, {30'h0, exp}, what);
   endtask
   task automatic check_drive(input logic [3:0] got, input logic [3:0] exp, input string what);
      check_word({28'h0, got}, {28'h0, exp}, what);
   endtask
   // Called right after a rising edge; returns one edge after the answer
   task automatic wr_chk(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_rdy) wv <= 1'b0;
      end while (bv !== 1'b1);
      check_resp(bresp, er, "write response");
      br <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      check_word(rd, ed, "read data");
      check_resp(rresp, er, "read response");
      rr <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [31:0] mode(input logic [1:0] dis, input logic drv, input logic inv, input logic blk);
      return {26'h0, blk, inv, 1'b0, drv, dis};
   endfunction
   // Lower-transistor on-time over n clocks; k whole individual periods fall inside the group-high time
   task automatic measure(input int n, input int k, input logic drv, input logic inv);
      int cnt[4];
      logic bad;
      bad = 1'b0;
      for (int c = 0; c < 4; c++) cnt[c] = 0;
      repeat (n) begin
         @(negedge clk);
         for (int c = 0; c < 4; c++) if (lo[c] === 1'b1) cnt[c]++;
         if (hi !== (drv ? ~lo : 4'h0) || cont !== 1'b0) bad = 1'b1;
      end
      check_word({31'h0, bad}, 32'h0, "upper versus lower");
      for (int c = 0; c < 4; c++)
         check_word(32'(cnt[c]), 32'(inv ? n - k * 2 * duty[c] : k * 2 * duty[c]), "low time");
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         $display("[FAIL] %0t run did not finish", $time);
         summarize();
      end
   end
   initial begin
      rst <= 1'b1;
      oe_n <= 1'b0;
      awv <= 1'b0;
      wv <= 1'b0;
      br <= 1'b0;
      arv <= 1'b0;
      rr <= 1'b0;
      awa <= 6'h00;
      ara <= 6'h00;
      wd <= 32'h0;
      ws <= 4'h0;
      duty = {8'h00, 8'h01, 8'hFF, 8'h80};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check_drive(hi, 4'hF, "reset upper");
      check_drive(lo, 4'h0, "reset lower");
      rd_chk(ADDR_MODE, 32'(MODE_RESET), RESP_OKAY);
      rd_chk(ADDR_STATE_SEL, 32'(STATE_SEL_RESET), RESP_OKAY);
      rd_chk(ADDR_GROUP_DUTY, 32'(GROUP_DUTY_RESET), RESP_OKAY);
      rd_chk(ADDR_DUTY3, 32'(DUTY_RESET), RESP_OKAY);
      rd_chk(6'h24, 32'h0, RESP_SLVERR);
      wr_chk(6'h24, 32'h12, 4'hF, RESP_SLVERR);
      wr_chk(ADDR_STATUS, 32'h7, 4'hF, RESP_OKAY);
      wr_chk(ADDR_GROUP_FREQ, 32'h55, 4'h0, RESP_OKAY);
      rd_chk(ADDR_GROUP_FREQ, 32'(GROUP_FREQ_RESET), RESP_OKAY);
      // Off and on states under every inversion and drive type
      for (int m = 0; m < 8; m++) begin
         wr_chk(ADDR_MODE, mode(DIS_HIGH, m[2], m[1], 1'b0), 4'hF, RESP_OKAY);
         wr_chk(ADDR_STATE_SEL, m[0] ? 32'h55 : 32'h00, 4'hF, RESP_OKAY);
         check_drive(lo, {4{m[0] ^ m[1]}}, "static lower");
         check_drive(hi, {4{~(m[0] ^ m[1]) & m[2]}}, "static upper");
      end
      // Override with inversion set and channels on; only the disabled field and, for the upper, the drive type count
      for (int m = 0; m < 8; m++) begin
         wr_chk(ADDR_MODE, mode(m[1:0], m[2], 1'b1, 1'b0), 4'hF, RESP_OKAY);
         oe_n <= 1'b1;
         #1;
         check_drive(lo, {4{m[1:0] == DIS_LOW}}, "override lower");
         check_drive(hi, {4{m[1:0] == DIS_HIGH && m[2]}}, "override upper");
         check_drive(pin, {4{m[1:0] != DIS_LOW}}, "override pin");
         @(posedge clk);
         oe_n <= 1'b0;
      end
      for (int c = 0; c < 4; c++) wr_chk(ADDR_DUTY0 + 6'(4 * c), 32'(duty[c]), 4'h1, RESP_OKAY);
      wr_chk(ADDR_STATE_SEL, 32'hAA, 4'hF, RESP_OKAY);
      // Totem not inverted, open-drain, totem inverted
      wr_chk(ADDR_MODE, mode(DIS_HIGH, 1'b1, 1'b0, 1'b0), 4'hF, RESP_OKAY);
      measure(512, 1, 1'b1, 1'b0);
      wr_chk(ADDR_MODE, mode(DIS_HIGH, 1'b0, 1'b0, 1'b0), 4'hF, RESP_OKAY);
      measure(512, 1, 1'b0, 1'b0);
      wr_chk(ADDR_MODE, mode(DIS_HIGH, 1'b1, 1'b1, 1'b0), 4'hF, RESP_OKAY);
      measure(512, 1, 1'b1, 1'b1);
      // Group dimming at half duty, one period of 1024 clocks
      wr_chk(ADDR_STATE_SEL, 32'hFF, 4'hF, RESP_OKAY);
      wr_chk(ADDR_GROUP_DUTY, 32'h80, 4'h1, RESP_OKAY);
      wr_chk(ADDR_MODE, mode(DIS_HIGH, 1'b1, 1'b0, 1'b0), 4'hF, RESP_OKAY);
      measure(1024, 1, 1'b1, 1'b0);
      wr_chk(ADDR_MODE, mode(DIS_HIGH, 1'b0, 1'b0, 1'b0), 4'hF, RESP_OKAY);
      measure(1024, 1, 1'b0, 1'b0);
      wr_chk(ADDR_MODE, mode(DIS_HIGH, 1'b0, 1'b1, 1'b0), 4'hF, RESP_OKAY);
      measure(1024, 1, 1'b0, 1'b1);
      // Blinking: step 3*8 clocks, period 6144, high 1536 at quarter duty
      wr_chk(ADDR_GROUP_FREQ, 32'h07, 4'h1, RESP_OKAY);
      wr_chk(ADDR_GROUP_DUTY, 32'h40, 4'h1, RESP_OKAY);
      wr_chk(ADDR_MODE, mode(DIS_HIGH, 1'b1, 1'b0, 1'b1), 4'hF, RESP_OKAY);
      measure(6144, 3, 1'b1, 1'b0);
      // Zero group duty holds the group level low; status shows blinking selected, pin enabled
      wr_chk(ADDR_GROUP_DUTY, 32'h00, 4'h1, RESP_OKAY);
      rd_chk(ADDR_STATUS, 32'h04, RESP_OKAY);
      rd_chk(ADDR_DUTY1, 32'(duty[1]), RESP_OKAY);
      summarize();
   end
endmodule
